/* testbench/bip_pins_model.sv */
// Board model: outside drivers, pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none
module bip_pins_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_n_o,
	input wire logic [7:0] pull_up_en_o,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_val_i,
	output logic [7:0] pin_i
);
	logic [7:0] last_q = 8'h00;
	// Floating lines toggle so a stale level is never trusted
	always_ff @(posedge clk_sys_i) last_q <= pin_i;
	assign pin_i = ~pin_oe_n_o & pin_o | pin_oe_n_o & (ext_en_i & ext_val_i | ~ext_en_i & (pull_up_en_o | ~last_q));
endmodule : bip_pins_model
`default_nettype wire

/* testbench/bip_port_monitor.sv */
// Checker of the port's pad control and register reads
`timescale 1ns/1ps
`default_nettype none
module bip_port_monitor (
	// Clock, reset, access
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire bip_pkg::bip_bus_req_type bus_i,
	input wire logic [7:0] rdata_o,
	// Pads
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_n_o,
	input wire logic [7:0] pull_up_en_o,
	input wire logic [7:0] analog_sel_o,
	// Interrupt requests
	input wire logic global_irq_enable_i,
	input wire logic [7:0] line_irq_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_latch_wr: assert property (
		bus_i.wr && bus_i.sel == 2'h0 |=> pin_o == $past(bus_i.wdata)) else $error("latch");
	a_rd_hold: assert property (!bus_i.rd |=> $stable(rdata_o)) else $error("rdata moved");
	a_gap_rd: assert property (bus_i.rd && bus_i.sel == 2'h3 |=> rdata_o == 8'h00) else $error("gap");
	a_pull_drv: assert property ((pull_up_en_o & ~pin_oe_n_o) == 8'h00) else $error("pull on output");
	a_analog_in: assert property ((analog_sel_o & (pull_up_en_o | ~pin_oe_n_o)) == 8'h00) else $error("mix");
	a_dir_input: assert property (
		bus_i.wr && bus_i.sel == 2'h1 && bus_i.wdata == 8'h00 |=> pin_oe_n_o == 8'hff) else $error("dir");
	a_od_low: assert property (
		bus_i.wr && bus_i.sel == 2'h2 && bus_i.wdata == 8'h00 |=> (pin_o & ~pin_oe_n_o) == 8'h00) else $error("od");
	a_opt_analog: assert property (
		bus_i.wr && bus_i.sel == 2'h2 && bus_i.wdata == 8'h00 |=> analog_sel_o == 8'h00) else $error("analog");
	a_irq_gate: assert property (
		irq_o == (global_irq_enable_i && line_irq_o != 8'h00)) else $error("irq gate");
endmodule : bip_port_monitor
bind bip_port bip_port_monitor u_bip_port_monitor (.clk_sys_i, .rst_n_i, .bus_i, .rdata_o, .pin_o, .pin_oe_n_o,
	.pull_up_en_o, .analog_sel_o, .global_irq_enable_i, .line_irq_o, .irq_o);
`default_nettype wire

/* testbench/tb_bip_port.sv */
// Self-checking bench of the bytewise I/O port
`timescale 1ns/1ps
`default_nettype none
module tb_bip_port;
	import bip_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	bip_bus_req_type bus_i = '0;
	logic level_select_bit_i = 1'b0, edge_rising_i = 1'b0, global_irq_enable_i = 1'b0;
	logic [7:0] ext_en_i = 8'h00, ext_val_i = 8'h00;
	logic [7:0] pin_i, rdata_o, pin_o, pin_oe_n_o, pull_up_en_o, analog_sel_o, line_irq_o;
	logic irq_o;
	int err_count = 0, checked = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	bip_port u_bip_port (.clk_sys_i, .rst_n_i, .bus_i, .rdata_o, .level_select_bit_i, .edge_rising_i,
		.global_irq_enable_i, .pin_i, .pin_o, .pin_oe_n_o, .pull_up_en_o, .analog_sel_o, .line_irq_o, .irq_o);
	bip_pins_model u_bip_pins_model (.clk_sys_i, .pin_o, .pin_oe_n_o, .pull_up_en_o, .ext_en_i, .ext_val_i, .pin_i);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// Strobe spans exactly one sampling edge
	task automatic acc(input logic wr, input logic [1:0] sel, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1 bus_i = '{wr, !wr, sel, d};
		@(posedge clk_sys_i);
		#1 bus_i = '0;
	endtask : acc
	task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
		acc(1'b0, sel, 8'h00);
		chk(rdata_o & BIP_IMPLEMENTED, exp & BIP_IMPLEMENTED);
	endtask : rd
	task automatic wait_irq(input logic [7:0] exp);
		for (int n = 0; n < 8 && line_irq_o !== exp; n++)
			@(posedge clk_sys_i) #1;
		chk(line_irq_o, exp);
		if (line_irq_o !== exp)
			summarize();
	endtask : wait_irq
	task automatic t_reset();
		chk(pin_oe_n_o, 8'hff);
		acc(1'b1, 2'h3, 8'h55);
		rd(BIP_SEL_DIRECTION, 8'h00);
		rd(BIP_SEL_PIN_LATCH, 8'hff);
		rd(2'h3, 8'h00);
	endtask : t_reset
	// Lines 0..7 take all six modes at once, one analog line only
	task automatic t_modes();
		acc(1'b1, BIP_SEL_OPTION, 8'h00);
		ext_en_i = 8'h0f;
		ext_val_i = 8'h05;
		acc(1'b1, BIP_SEL_DIRECTION, 8'hf0);
		acc(1'b1, BIP_SEL_OPTION, 8'hcc);
		acc(1'b1, BIP_SEL_PIN_LATCH, 8'haa);
		chk(pin_oe_n_o, 8'h2f);
		chk(pin_o, 8'haa);
		chk(pull_up_en_o, 8'h05);
		chk(analog_sel_o, 8'h08);
		rd(BIP_SEL_PIN_LATCH, 8'ha5);
	endtask : t_modes
	task automatic t_irq();
		global_irq_enable_i = 1'b1;
		ext_val_i = 8'h02;
		wait_irq(8'h04);
		chk({7'h00, irq_o}, 8'h01);
		@(posedge clk_sys_i) #1;
		chk(line_irq_o, 8'h00);
		edge_rising_i = 1'b1;
		ext_val_i = 8'h0d;
		wait_irq(8'h04);
		@(posedge clk_sys_i) #1;
		level_select_bit_i = 1'b1;
		ext_val_i = 8'h02;
		wait_irq(8'h04);
		repeat (4) @(posedge clk_sys_i) #1;
		chk(line_irq_o, 8'h04);
		global_irq_enable_i = 1'b0;
		#1 chk({7'h00, irq_o}, 8'h00);
		acc(1'b1, BIP_SEL_DIRECTION, 8'h00);
		chk(pin_oe_n_o, 8'hff);
	endtask : t_irq
	// Reset in mid-run must clear configuration again
	task automatic t_mid_reset();
		ext_en_i = 8'h00;
		acc(1'b1, BIP_SEL_OPTION, 8'hff);
		acc(1'b1, BIP_SEL_DIRECTION, 8'hff);
		#2 rst_n_i = 1'b0;
		@(posedge clk_sys_i) #1;
		chk(pin_oe_n_o, 8'hff);
		chk(pull_up_en_o, 8'hff);
		chk(line_irq_o, 8'h00);
		rst_n_i = 1'b1;
		rd(BIP_SEL_OPTION, 8'h00);
		rd(BIP_SEL_DIRECTION, 8'h00);
		rd(BIP_SEL_PIN_LATCH, 8'hff);
	endtask : t_mid_reset
	initial begin
		repeat (20) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		t_reset();
		t_modes();
		t_irq();
		t_mid_reset();
		summarize();
	end
endmodule : tb_bip_port
`default_nettype wire

/* verilog/bip_pkg.sv */
// Package of constants and types for the bytewise I/O port
package bip_pkg;
	// ----------------------------------------
	// Register selects
	// ----------------------------------------
	localparam logic [1:0] BIP_SEL_PIN_LATCH = 2'h0;
	localparam logic [1:0] BIP_SEL_DIRECTION = 2'h1;
	localparam logic [1:0] BIP_SEL_OPTION = 2'h2;
	localparam int BIP_REG_COUNT = 3;
	localparam int BIP_WIDTH = 8;
	localparam logic [7:0] BIP_RST_PIN_LATCH = 8'h00;
	localparam logic [7:0] BIP_RST_DIRECTION = 8'h00;
	localparam logic [7:0] BIP_RST_OPTION = 8'h00;
	localparam logic [7:0] BIP_ANALOG_CAPABLE = 8'hff;
	localparam logic [7:0] BIP_IMPLEMENTED = 8'hff;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		BIP_TRIG_FALL,
		BIP_TRIG_RISE,
		BIP_TRIG_LOW
	} bip_trig_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] sel;
		logic [7:0] wdata;
	} bip_bus_req_type;

	typedef struct packed {
		logic [7:0] drive_low_n;
		logic [7:0] pull_up_en;
		logic [7:0] analog_sel;
		logic [7:0] irq_line_en;
	} bip_pad_ctl_type;
endpackage : bip_pkg

/* verilog/bip_port.sv */
// Bytewise general-purpose I/O port: registers, pad control, interrupt requests
// ----------------------------------------
// Functional notes
// - Three byte registers, one bit per line
// - Inputs read pins; outputs drive latch bit
// - Input reads from pins; writes update latch
// - Direction bit: 0 input, 1 output
// - Reset clears all three registers
// - 000: input, pull-up, no interrupt
// - 001: input, high impedance, no interrupt
// - 010: input, pull-up, interrupt connected
// - 011: analog input to multiplexer
// - Direction 1, option 0: open drain
// - Direction 1, option 1: push-pull latch value
// - Trigger: falling, rising or low level
// - Bit operations read and rewrite whole byte
// - Registers accessed like data-space RAM
// - Level select: level else edge
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bip_port (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Data-space access
	input wire bip_pkg::bip_bus_req_type bus_i,
	output logic [7:0] rdata_o,
	// Interrupt configuration from the interrupt logic
	input wire logic level_select_bit_i,
	input wire logic edge_rising_i,
	input wire logic global_irq_enable_i,
	// Pins
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_n_o,
	output logic [7:0] pull_up_en_o,
	output logic [7:0] analog_sel_o,
	// Interrupt requests
	output logic [7:0] line_irq_o,
	output logic irq_o
);
	import bip_pkg::*;

	logic [7:0] pin_latch_reg;
	logic [7:0] port_direction;
	logic [7:0] port_option;

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	bip_regfile u_regs (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_i(bus_i.wr),
		.sel_i(bus_i.sel),
		.wdata_i(bus_i.wdata),
		.latch_o(pin_latch_reg),
		.dir_o(port_direction),
		.opt_o(port_option)
	);

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	// First stage is read only by the second
	logic [7:0] sync1_q, sync1_d;
	logic [7:0] sync2_q, sync2_d;
	logic [7:0] prev_q, prev_d;

	always_comb begin
		sync1_d = pin_i;
		sync2_d = sync1_q;
		prev_d = sync2_q;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 8'hff;
			sync2_q <= 8'hff;
			prev_q <= 8'hff;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q <= prev_d;
		end
	end

	// ----------------------------------------
	// Pad configuration decode
	// ----------------------------------------
	function automatic bip_pad_ctl_type bip_decode(input logic [7:0] dir, input logic [7:0] opt,
			input logic [7:0] lat);
		bip_pad_ctl_type c;
		c.drive_low_n = 8'hff;
		c.pull_up_en = 8'h00;
		c.analog_sel = 8'h00;
		c.irq_line_en = 8'h00;
		for (int i = 0; i < BIP_WIDTH; i++) begin
			unique case ({dir[i], opt[i], lat[i]})
				3'b000: c.pull_up_en[i] = 1'b1;
				3'b001: ;
				3'b010: begin
					c.pull_up_en[i] = 1'b1;
					c.irq_line_en[i] = 1'b1;
				end
				3'b011: c.analog_sel[i] = BIP_ANALOG_CAPABLE[i];
				default: c.drive_low_n[i] = 1'b0;
			endcase
		end
		return c;
	endfunction : bip_decode

	bip_pad_ctl_type pad;
	assign pad = bip_decode(port_direction, port_option, pin_latch_reg);

	// Output enable low means driving; open drain only drives a zero
	always_comb begin
		for (int i = 0; i < BIP_WIDTH; i++) begin
			pin_o[i] = pin_latch_reg[i];
			if (!port_direction[i]) begin
				pin_oe_n_o[i] = 1'b1;
			end else if (port_option[i]) begin
				pin_oe_n_o[i] = 1'b0;
			end else begin
				pin_oe_n_o[i] = pin_latch_reg[i];
			end
		end
	end

	assign pull_up_en_o = pad.pull_up_en;
	assign analog_sel_o = pad.analog_sel;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Mixed byte: input lines from pins, output lines from latch
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		rdata_d = rdata_q;
		if (bus_i.rd) begin
			unique case (bus_i.sel)
				BIP_SEL_PIN_LATCH: rdata_d = (sync2_q & ~port_direction) |
					(pin_latch_reg & port_direction);
				BIP_SEL_DIRECTION: rdata_d = port_direction;
				BIP_SEL_OPTION: rdata_d = port_option;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Read-modify-write of single bits is done by the core, so a bit
	// operation rewrites the pin-sourced input bits into the latch
	assign rdata_o = rdata_q;

	// ----------------------------------------
	// Interrupt detection
	// ----------------------------------------
	logic [7:0] irq_q, irq_d;

	always_comb begin
		for (int i = 0; i < BIP_WIDTH; i++) begin
			if (!pad.irq_line_en[i]) begin
				irq_d[i] = 1'b0;
			end else if (level_select_bit_i) begin
				irq_d[i] = ~sync2_q[i];
			end else if (edge_rising_i) begin
				irq_d[i] = sync2_q[i] & ~prev_q[i];
			end else begin
				irq_d[i] = ~sync2_q[i] & prev_q[i];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_q <= 8'h00;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign line_irq_o = irq_q;
	assign irq_o = global_irq_enable_i & (|irq_q);
endmodule : bip_port
`default_nettype wire

/* verilog/bip_regfile.sv */
// Three byte registers of the port; read data is registered in bip_port
`timescale 1ns/1ps
`default_nettype none
module bip_regfile (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Access
	input wire logic wr_i,
	input wire logic [1:0] sel_i,
	input wire logic [7:0] wdata_i,
	// Contents
	output logic [7:0] latch_o,
	output logic [7:0] dir_o,
	output logic [7:0] opt_o
);
	import bip_pkg::*;

	logic [7:0] latch_q, latch_d;
	logic [7:0] dir_q, dir_d;
	logic [7:0] opt_q, opt_d;

	always_comb begin
		latch_d = latch_q;
		dir_d = dir_q;
		opt_d = opt_q;
		if (wr_i) begin
			// Writes always reach the latch, even for input lines
			unique case (sel_i)
				BIP_SEL_PIN_LATCH: latch_d = wdata_i;
				BIP_SEL_DIRECTION: dir_d = wdata_i;
				BIP_SEL_OPTION: opt_d = wdata_i;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch_q <= BIP_RST_PIN_LATCH;
			dir_q <= BIP_RST_DIRECTION;
			opt_q <= BIP_RST_OPTION;
		end else begin
			latch_q <= latch_d;
			dir_q <= dir_d;
			opt_q <= opt_d;
		end
	end

	assign latch_o = latch_q;
	assign dir_o = dir_q;
	assign opt_o = opt_q;
endmodule : bip_regfile
`default_nettype wire
